// [verilog/timer16_params.svh]
// Offsets, masks, reset values and divider constants of the timer control block
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH
`define IDX_MODE 16'hff60
`define IDX_PRESCALE 16'hff61
`define IDX_CCCTL 16'hff62
`define IDX_OUTCTL 16'hff63
`define IDX_CCA 16'hff64
`define IDX_CCB 16'hff65
`define IDX_COUNT 16'hff66
`define ADDR_OF(i) {14'h0000, i, 2'b00}
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define MODE_MASK 8'h0f
`define PRESCALE_MASK 8'hf3
`define CCCTL_MASK 8'h07
`define OUTCTL_KEEP 8'h13
`define DIV4_MASK 6'h03
`define DIV8_MASK 6'h07
`define DIV64_MASK 6'h3f
`define DIV_ZERO 6'h00
`define DIV_ONE 6'h01
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define CNT_MAX 16'hffff
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define DATA_ZERO 32'h00000000
`endif

// [verilog/timer16_pkg.sv]
// Register layouts and mode encodings of the timer control block
package timer16_pkg;
    typedef enum logic [1:0] {MODE_STOP = 2'b00, MODE_FREE = 2'b01, MODE_CLR_IN = 2'b10,
                              MODE_CLR_MATCH = 2'b11} mode_e;
    typedef enum logic [1:0] {EDGE_FALL = 2'b00, EDGE_RISE = 2'b01, EDGE_BAD = 2'b10,
                              EDGE_BOTH = 2'b11} edge_e;
    typedef enum logic [1:0] {CLK_FX = 2'b00, CLK_DIV4 = 2'b01, CLK_DIV64 = 2'b10,
                              CLK_EXT = 2'b11} clk_e;
    typedef struct packed {
        logic [3:0] zero;
        logic mode_sel_hi;
        logic mode_sel_mid;
        logic mode_sel_lo;
        logic overflow_flag;
    } mode_s;
    typedef struct packed {
        logic [1:0] edge_sel_in2;
        logic [1:0] edge_sel_in1;
        logic [1:0] zero;
        logic [1:0] clk_sel;
    } prescale_s;
    typedef struct packed {
        logic [4:0] zero;
        logic capcomp_b_capture_en;
        logic capcomp_a_trigger_sel;
        logic capcomp_a_capture_en;
    } ccctl_s;
    typedef struct packed {
        logic [2:0] zero;
        logic invert_on_match_b;
        logic out_ff_set;
        logic out_ff_clear;
        logic invert_on_match_a;
        logic out_enable;
    } outctl_s;
endpackage

// [verilog/timer16_control_regs.sv]
// 16-bit timer/event counter with its control registers behind an AXI4-Lite slave
`timescale 1ns/100ps
`include "timer16_params.svh"
module timer16_control_regs
    import timer16_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Timer pins
    input wire logic timer_input_1,
    input wire logic timer_input_2,
    output logic timer_output,
    // Match and capture requests
    output logic match_irq_a,
    output logic match_irq_b
);
    // Control registers
    mode_s mode_ctl;
    prescale_s prs;
    ccctl_s cc;
    outctl_s out_ctl;
    // Timer datapath
    logic [15:0] up_counter;
    logic [15:0] capcomp_reg_a;
    logic [15:0] capcomp_reg_b;
    logic out_ff;
    logic [5:0] div_cnt;
    // Pin synchronisers, sample history, filtered level
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] samp_prev;
    logic [1:0] filt;
    logic seen_run;
    // Registered edge pulses
    logic edge1;
    logic opp1;
    logic edge2;
    // Write channel state; rd_out_q remembers a read of the output control register
    logic aw_have;
    logic w_have;
    logic [31:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic rd_out_q;

    // Edge selection; the banned 10 code detects nothing
    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        case (edge_e'(sel))
            EDGE_FALL: edge_hit = f;
            EDGE_RISE: edge_hit = r;
            EDGE_BOTH: edge_hit = r | f;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    // Opposite edge of input 1; none when both edges are chosen
    function automatic logic opp_hit(input logic [1:0] sel, input logic r, input logic f);
        case (edge_e'(sel))
            EDGE_FALL: opp_hit = r;
            EDGE_RISE: opp_hit = f;
            default: opp_hit = 1'b0;
        endcase
    endfunction

    // Mode decode
    wire mode_e mode = mode_e'({mode_ctl.mode_sel_hi, mode_ctl.mode_sel_mid});
    wire running = mode != MODE_STOP;
    wire clk_e csel = clk_e'(prs.clk_sel);

    // Prescaler taps
    wire div4 = (div_cnt & `DIV4_MASK) == `DIV4_MASK;
    wire div8 = (div_cnt & `DIV8_MASK) == `DIV8_MASK;
    wire div64 = div_cnt == `DIV64_MASK;
    // Count clock enable per selection
    wire cnt_clk = (csel == CLK_FX) ? 1'b1 : (csel == CLK_DIV4) ? div4 :
                   (csel == CLK_DIV64) ? div64 : edge1;
    wire tick = running & cnt_clk;
    // External clock cannot sample itself, so fx/8 samples the pins then
    wire samp_en = ((csel == CLK_EXT) ? div8 : cnt_clk) & (running | seen_run);

    // Two agreeing samples move the filtered level
    wire [1:0] next_filt = (sync_b & samp_prev) | (filt & (sync_b | samp_prev));
    wire [1:0] rise = next_filt & ~filt;
    wire [1:0] fall = ~next_filt & filt;

    // Compare matches, only for registers in compare role
    wire eq_a = up_counter == capcomp_reg_a;
    wire eq_b = up_counter == capcomp_reg_b;
    wire match_a = tick & ~cc.capcomp_a_capture_en & eq_a;
    wire match_b = tick & ~cc.capcomp_b_capture_en & eq_b;
    // Capture triggers
    wire trig_a = cc.capcomp_a_trigger_sel ? opp1 : edge2;
    wire cap_a = running & cc.capcomp_a_capture_en & trig_a;
    wire cap_b = running & cc.capcomp_b_capture_en & edge1;

    // Output flip-flop toggle sources
    wire tog_in = running & mode_ctl.mode_sel_lo & edge1;
    wire tog = (match_a & out_ctl.invert_on_match_a) ^ (match_b & out_ctl.invert_on_match_b) ^ tog_in;

    // Counter next value per mode
    logic [15:0] next_counter;
    logic edge_clear;
    always_comb begin
        edge_clear = 1'b0;
        next_counter = up_counter;
        case (mode)
            MODE_STOP: next_counter = `CNT_ZERO;
            MODE_FREE: if (tick) begin
                next_counter = up_counter + `CNT_ONE;
            end
            MODE_CLR_IN: if (edge1) begin
                edge_clear = 1'b1;
                next_counter = `CNT_ZERO;
            end else if (tick) begin
                next_counter = up_counter + `CNT_ONE;
            end
            MODE_CLR_MATCH: if (tick) begin
                next_counter = eq_a ? `CNT_ZERO : up_counter + `CNT_ONE;
            end
            default: next_counter = `CNT_ZERO;
        endcase
    end
    // Rolling over from all ones, including a match-clear at all ones
    wire ovf_set = tick & (up_counter == `CNT_MAX) & ~edge_clear;

    // Write decode
    wire w_lane0 = w_strb_q[0];
    wire w_lane1 = w_strb_q[1];
    wire do_wr = aw_have & w_have & ~bvalid;
    wire hit_mode = aw_addr_q == `ADDR_OF(`IDX_MODE);
    wire hit_prs = aw_addr_q == `ADDR_OF(`IDX_PRESCALE);
    wire hit_cc = aw_addr_q == `ADDR_OF(`IDX_CCCTL);
    wire hit_out = aw_addr_q == `ADDR_OF(`IDX_OUTCTL);
    wire hit_cca = aw_addr_q == `ADDR_OF(`IDX_CCA);
    wire hit_ccb = aw_addr_q == `ADDR_OF(`IDX_CCB);
    wire hit_cnt = aw_addr_q == `ADDR_OF(`IDX_COUNT);
    wire w_mapped = hit_mode | hit_prs | hit_cc | hit_out | hit_cca | hit_ccb | hit_cnt;
    wire wr_mode = do_wr & hit_mode & w_lane0;
    wire wr_prs = do_wr & hit_prs & w_lane0;
    wire wr_cc = do_wr & hit_cc & w_lane0;
    wire wr_out = do_wr & hit_out & w_lane0;
    wire mode_s wmode = mode_s'(w_data_q[7:0] & `MODE_MASK);
    wire outctl_s wout = outctl_s'(w_data_q[7:0]);
    // Both upper mode bits written to zero stop a running timer
    wire wr_stop = ~wmode.mode_sel_hi & ~wmode.mode_sel_mid;

    // Read decode
    wire r_mode = araddr == `ADDR_OF(`IDX_MODE);
    wire r_prs = araddr == `ADDR_OF(`IDX_PRESCALE);
    wire r_cc = araddr == `ADDR_OF(`IDX_CCCTL);
    wire r_out = araddr == `ADDR_OF(`IDX_OUTCTL);
    wire r_cca = araddr == `ADDR_OF(`IDX_CCA);
    wire r_ccb = araddr == `ADDR_OF(`IDX_CCB);
    wire r_cnt = araddr == `ADDR_OF(`IDX_COUNT);
    wire r_mapped = r_mode | r_prs | r_cc | r_out | r_cca | r_ccb | r_cnt;
    // Set and clear bits are never stored, so they read as zero
    wire [31:0] rd_mux = r_mode ? {24'h000000, mode_ctl} : r_prs ? {24'h000000, prs} :
                         r_cc ? {24'h000000, cc} : r_out ? {24'h000000, out_ctl} :
                         r_cca ? {16'h0000, capcomp_reg_a} : r_ccb ? {16'h0000, capcomp_reg_b} :
                         r_cnt ? {16'h0000, up_counter} : `DATA_ZERO;

    // Handshake next states
    wire aw_go = awvalid & awready;
    wire w_go = wvalid & wready;
    wire ar_go = arvalid & arready;
    wire next_aw_have = (aw_have | aw_go) & ~do_wr;
    wire next_w_have = (w_have | w_go) & ~do_wr;
    wire next_rvalid = ar_go | (rvalid & ~rready);

    // Write address and data holding; either may come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            awready <= ~next_aw_have;
            wready <= ~next_w_have;
        end
    end

    // Captured write payload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= `DATA_ZERO;
            w_data_q <= `DATA_ZERO;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_go) begin
                aw_addr_q <= awaddr;
            end
            if (w_go) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= `DATA_ZERO;
            rresp <= `RESP_OKAY;
            rd_out_q <= 1'b0;
        end else begin
            arready <= ~next_rvalid;
            rvalid <= next_rvalid;
            if (ar_go) begin
                rdata <= rd_mux;
                rresp <= r_mapped ? `RESP_OKAY : `RESP_SLVERR;
                rd_out_q <= r_out;
            end
        end
    end

    // Mode register: while running, a write that does not stop the timer changes only the overflow flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ctl <= mode_s'(`RST_BYTE);
        end else begin
            // Without the stop exception a running timer could never be halted
            if (wr_mode && (!running || wr_stop)) begin
                mode_ctl <= wmode;
            end else if (wr_mode) begin
                mode_ctl.overflow_flag <= wmode.overflow_flag;
            end
            // A rollover in the same cycle as a clear still lands
            if (ovf_set) begin
                mode_ctl.overflow_flag <= 1'b1;
            end
        end
    end

    // Other control registers; software stops the timer first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prs <= prescale_s'(`RST_BYTE);
            cc <= ccctl_s'(`RST_BYTE);
            out_ctl <= outctl_s'(`RST_BYTE);
        end else begin
            if (wr_prs) begin
                prs <= prescale_s'(w_data_q[7:0] & `PRESCALE_MASK);
            end
            if (wr_cc) begin
                cc <= ccctl_s'(w_data_q[7:0] & `CCCTL_MASK);
            end
            if (wr_out) begin
                out_ctl <= outctl_s'(w_data_q[7:0] & `OUTCTL_KEEP);
            end
        end
    end

    // Free-running prescaler
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= `DIV_ZERO;
        end else begin
            div_cnt <= div_cnt + `DIV_ONE;
        end
    end

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 2'b00;
            sync_b <= 2'b00;
        end else begin
            sync_a <= {timer_input_2, timer_input_1};
            sync_b <= sync_a;
        end
    end

    // Sampling and edge pulses; the level starts low so a high pin
    // gives a rising edge at first enable, but not after a later stop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samp_prev <= 2'b00;
            filt <= 2'b00;
            seen_run <= 1'b0;
            edge1 <= 1'b0;
            opp1 <= 1'b0;
            edge2 <= 1'b0;
        end else begin
            seen_run <= seen_run | running;
            edge1 <= samp_en & edge_hit(prs.edge_sel_in1, rise[0], fall[0]);
            opp1 <= samp_en & opp_hit(prs.edge_sel_in1, rise[0], fall[0]);
            edge2 <= samp_en & edge_hit(prs.edge_sel_in2, rise[1], fall[1]);
            if (samp_en) begin
                samp_prev <= sync_b;
                filt <= next_filt;
            end
        end
    end

    // Counter and capture registers; a capture beats a software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_counter <= `CNT_ZERO;
            capcomp_reg_a <= `RST_WORD;
            capcomp_reg_b <= `RST_WORD;
        end else begin
            up_counter <= next_counter;
            if (cap_a) begin
                capcomp_reg_a <= up_counter;
            end else if (do_wr && hit_cca) begin
                if (w_lane0) capcomp_reg_a[7:0] <= w_data_q[7:0];
                if (w_lane1) capcomp_reg_a[15:8] <= w_data_q[15:8];
            end
            if (cap_b) begin
                capcomp_reg_b <= up_counter;
            end else if (do_wr && hit_ccb) begin
                if (w_lane0) capcomp_reg_b[7:0] <= w_data_q[7:0];
                if (w_lane1) capcomp_reg_b[15:8] <= w_data_q[15:8];
            end
        end
    end

    // Output flip-flop: a lone software set or clear overrides toggling; set and clear together do not
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_ff <= 1'b0;
        end else if (wr_out && wout.out_ff_set && !wout.out_ff_clear) begin
            out_ff <= 1'b1;
        end else if (wr_out && wout.out_ff_clear && !wout.out_ff_set) begin
            out_ff <= 1'b0;
        end else if (tog) begin
            out_ff <= ~out_ff;
        end
    end

    // Pin and request outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_output <= 1'b0;
            match_irq_a <= 1'b0;
            match_irq_b <= 1'b0;
        end else begin
            timer_output <= out_ff & out_ctl.out_enable;
            match_irq_a <= match_a | cap_a;
            match_irq_b <= match_b | cap_b;
        end
    end

    // Read data seen through the output control layout
    wire outctl_s rd_oc = outctl_s'(rdata[7:0]);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_stop_clears: assert property (!running |=> up_counter == `CNT_ZERO)
        else $error("counter not cleared while stopped");
    a_free_counts: assert property ((mode == MODE_FREE && tick) |=> up_counter == $past(up_counter) + `CNT_ONE)
        else $error("free-running count did not advance");
    a_ovf_flag: assert property (ovf_set |=> mode_ctl.overflow_flag)
        else $error("overflow flag not set");
    a_match_roll: assert property ((mode == MODE_CLR_MATCH && tick && capcomp_reg_a == `CNT_MAX && eq_a)
        |=> up_counter == `CNT_ZERO && mode_ctl.overflow_flag)
        else $error("all-ones match did not roll and flag");
    a_cap_b_load: assert property (cap_b |=> capcomp_reg_b == $past(up_counter))
        else $error("capture b lost counter value");
    a_no_opp_both: assert property ((prs.edge_sel_in1 == EDGE_BOTH) |=> !opp1)
        else $error("opposite edge seen with both edges");
    a_ff_read_zero: assert property ((rvalid && rd_out_q) |-> !rd_oc.out_ff_set && !rd_oc.out_ff_clear)
        else $error("set or clear bit read back nonzero");
    a_out_gated: assert property (!out_ctl.out_enable |=> !timer_output)
        else $error("output not forced low");
    a_inv_a_toggle: assert property ((match_a && out_ctl.invert_on_match_a && !match_b && !tog_in && !wr_out)
        |=> out_ff != $past(out_ff) ##1 timer_output == ($past(out_ff) & $past(out_ctl.out_enable)))
        else $error("match a did not invert output");
    a_irq_pulse: assert property (match_a |=> match_irq_a)
        else $error("match request a missing");

    c_free_overflow: cover property (mode == MODE_FREE && ovf_set);
    c_capture_a_opp: cover property (cap_a && cc.capcomp_a_trigger_sel);
    c_output_toggle: cover property (tog && out_ctl.out_enable);
    c_edge_clear: cover property (edge_clear && running);
endmodule

// [verif/timer_pin_source.sv]
// Model of the pulse sources that drive both timer input pins
`timescale 1ns/100ps
module timer_pin_source #(
    parameter int MIN_HOLD = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Levels requested by the bench
    input wire logic cmd_1,
    input wire logic cmd_2,
    // Pins toward the timer
    output logic timer_input_1,
    output logic timer_input_2
);
    // Cycles each pin has held its present level
    int held_1;
    int held_2;
    // A change waits until the old level stood long enough to be sampled twice
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_input_1 <= 1'b0;
            timer_input_2 <= 1'b0;
            held_1 <= 0;
            held_2 <= 0;
        end else begin
            held_1 <= held_1 + 1;
            held_2 <= held_2 + 1;
            // Short pulses would be lost as noise, so never emit them
            if (cmd_1 != timer_input_1 && held_1 >= MIN_HOLD) begin
                timer_input_1 <= cmd_1;
                held_1 <= 0;
            end
            if (cmd_2 != timer_input_2 && held_2 >= MIN_HOLD) begin
                timer_input_2 <= cmd_2;
                held_2 <= 0;
            end
        end
    end
endmodule

// [verif/test_timer16_control_regs.sv]
// Self-checking bench of the timer control block over its register bus
`timescale 1ns/100ps
`include "timer16_params.svh"
module test_timer16_control_regs;
    // Bus and pin signals, all idle at time zero
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic in_1, in_2, timer_output, match_irq_a, match_irq_b;
    logic cmd_1 = 1'b0, cmd_2 = 1'b0;
    logic [31:0] rv, rv2;
    int error_cnt = 0, tests_run = 0, cyc = 0, n;
    // 125 MHz clock
    always #4 aclk = ~aclk;
    timer16_control_regs dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer_input_1(in_1), .timer_input_2(in_2), .timer_output(timer_output),
        .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));
    timer_pin_source src (.aclk(aclk), .aresetn(aresetn), .cmd_1(cmd_1), .cmd_2(cmd_2),
        .timer_input_1(in_1), .timer_input_2(in_2));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Write one word; address and data released each at its own handshake
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= `ADDR_OF(idx);
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    // Read one word, data taken at the rvalid edge
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= `ADDR_OF(idx);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Read and compare
    task automatic rc(input logic [15:0] idx, input logic [31:0] exp);
        rd(idx, rv, resp);
        chk(rv, exp);
    endtask
    // Wait a bounded time for a request pulse
    task automatic wait_irq(input bit b, input int lim);
        n = 0;
        while (((b ? match_irq_b : match_irq_a) !== 1'b1) && n < lim) begin
            @(posedge aclk);
            n++;
        end
        chk({31'h0, n < lim}, 32'h1);
    endtask
    // Single closing point
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, above the long overflow wait
    always @(posedge aclk) begin
        cyc++;
        if (cyc >= 90000) begin
            error_cnt++;
            give_verdict;
        end
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++) rc(16'(16'hff60 + i), `DATA_ZERO);
        // Unmapped place refused both ways
        rd(16'hff70, rv, resp);
        chk({30'h0, resp}, 32'h2);
        chk(rv, `DATA_ZERO);
        wr(16'hff70, 32'h000000ff, resp);
        chk({30'h0, resp}, 32'h2);
        // Set and clear read zero, output follows enable
        wr(`IDX_OUTCTL, 32'h000000fb, resp);
        rc(`IDX_OUTCTL, 32'h13);
        repeat (3) @(posedge aclk);
        chk({31'h0, timer_output}, 32'h1);
        wr(`IDX_OUTCTL, 32'h00000008, resp);
        repeat (3) @(posedge aclk);
        chk({31'h0, timer_output}, 32'h0);
        wr(`IDX_OUTCTL, 32'h00000005, resp);
        repeat (3) @(posedge aclk);
        chk({31'h0, timer_output}, 32'h0);
        wr(`IDX_PRESCALE, 32'h000000ff, resp);
        rc(`IDX_PRESCALE, 32'hf3);
        wr(`IDX_CCCTL, 32'h000000ff, resp);
        rc(`IDX_CCCTL, 32'h07);
        wr(`IDX_MODE, 32'h000000f0, resp);
        rc(`IDX_MODE, 32'h00);
        wr(`IDX_CCCTL, 32'h0, resp);
        wr(`IDX_PRESCALE, 32'h0, resp);
        // Compare matches on b, then a, each invert the output
        wr(`IDX_CCA, 32'h00000020, resp);
        wr(`IDX_CCB, 32'h00000010, resp);
        wr(`IDX_OUTCTL, 32'h00000013, resp);
        wr(`IDX_MODE, 32'h00000004, resp);
        wait_irq(1'b1, 100);
        repeat (3) @(posedge aclk);
        chk({31'h0, timer_output}, 32'h1);
        wait_irq(1'b0, 100);
        repeat (3) @(posedge aclk);
        chk({31'h0, timer_output}, 32'h0);
        wr(`IDX_MODE, 32'h0, resp);
        rc(`IDX_COUNT, 32'h0);
        // Input edge toggles the output when the low mode bit is set
        wr(`IDX_OUTCTL, 32'h00000005, resp);
        wr(`IDX_PRESCALE, 32'h00000010, resp);
        wr(`IDX_MODE, 32'h00000006, resp);
        cmd_1 <= 1'b1;
        repeat (14) @(posedge aclk);
        chk({31'h0, timer_output}, 32'h1);
        cmd_1 <= 1'b0;
        wr(`IDX_MODE, 32'h0, resp);
        // Rising edge captures into b, falling edge into a
        wr(`IDX_CCCTL, 32'h00000007, resp);
        wr(`IDX_MODE, 32'h00000004, resp);
        cmd_1 <= 1'b1;
        wait_irq(1'b1, 40);
        n = 0;
        repeat (10) @(posedge aclk) n += match_irq_a;
        chk(n, 0);
        cmd_1 <= 1'b0;
        wait_irq(1'b0, 40);
        rd(`IDX_CCB, rv2, resp);
        rd(`IDX_CCA, rv, resp);
        chk({31'h0, rv > rv2}, 32'h1);
        wr(`IDX_MODE, 32'h0, resp);
        // Both edges selected: no capture into a
        wr(`IDX_PRESCALE, 32'h00000030, resp);
        wr(`IDX_MODE, 32'h00000004, resp);
        cmd_1 <= 1'b1;
        n = 0;
        repeat (30) @(posedge aclk) n += match_irq_a;
        cmd_1 <= 1'b0;
        repeat (30) @(posedge aclk) n += match_irq_a;
        chk(n, 0);
        wr(`IDX_MODE, 32'h0, resp);
        // Clear-on-input mode restarts the count at the valid edge
        wr(`IDX_CCCTL, 32'h0, resp);
        wr(`IDX_PRESCALE, 32'h00000010, resp);
        wr(`IDX_MODE, 32'h00000008, resp);
        repeat (40) @(posedge aclk);
        cmd_1 <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(`IDX_COUNT, rv, resp);
        chk({31'h0, rv < 32'h20}, 32'h1);
        wr(`IDX_MODE, 32'h0, resp);
        // Divided count clocks: a quarter, then a sixty-fourth of the cycles
        wr(`IDX_PRESCALE, 32'h00000001, resp);
        wr(`IDX_MODE, 32'h00000004, resp);
        repeat (80) @(posedge aclk);
        rd(`IDX_COUNT, rv, resp);
        chk({31'h0, rv >= 32'h13 && rv <= 32'h16}, 32'h1);
        wr(`IDX_MODE, 32'h0, resp);
        wr(`IDX_PRESCALE, 32'h00000002, resp);
        wr(`IDX_MODE, 32'h00000004, resp);
        repeat (640) @(posedge aclk);
        rd(`IDX_COUNT, rv, resp);
        chk({31'h0, rv >= 32'h9 && rv <= 32'hc}, 32'h1);
        wr(`IDX_MODE, 32'h0, resp);
        // Rising edges of input 1 as the count clock; no edge clear, no capture
        wr(`IDX_PRESCALE, 32'h00000013, resp);
        wr(`IDX_MODE, 32'h00000004, resp);
        cmd_1 <= 1'b0;
        repeat (60) @(posedge aclk);
        cmd_1 <= 1'b1;
        repeat (60) @(posedge aclk);
        rd(`IDX_COUNT, rv, resp);
        chk(rv, 32'h1);
        wr(`IDX_MODE, 32'h0, resp);
        // All-ones compare in match-clear mode raises overflow
        wr(`IDX_PRESCALE, 32'h0, resp);
        wr(`IDX_CCA, 32'h0000ffff, resp);
        wr(`IDX_MODE, 32'h0000000c, resp);
        repeat (65600) @(posedge aclk);
        rc(`IDX_MODE, 32'h0d);
        wr(`IDX_MODE, 32'h0000000c, resp);
        rc(`IDX_MODE, 32'h0c);
        wr(`IDX_MODE, 32'h0, resp);
        // Second reset with input 1 high: only the first enable sees an edge
        aresetn <= 1'b0;
        cmd_1 <= 1'b1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (24) @(posedge aclk);
        wr(`IDX_OUTCTL, 32'h00000001, resp);
        wr(`IDX_PRESCALE, 32'h00000010, resp);
        wr(`IDX_MODE, 32'h00000006, resp);
        repeat (14) @(posedge aclk);
        chk({31'h0, timer_output}, 32'h1);
        wr(`IDX_MODE, 32'h0, resp);
        wr(`IDX_MODE, 32'h00000006, resp);
        repeat (14) @(posedge aclk);
        chk({31'h0, timer_output}, 32'h1);
        give_verdict;
    end
endmodule
